// ### rtl/lts_top.v
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "lts_regs.vh"
// Function
// RL1: Shapes play out in programmed order.
// RL2: Shape is sine, shape_a, clipped sine, table.
// RL3: Clipped sine clips both peaks at clip level.
// RL4: Output peak never above 425 V; sine 300.
// RL5: Table points checked at start; error blocks run.
// RL6: Repeat value 0..99 per point, in order.
// RL7: Single-step advances one point per trigger.
// RL8: Single-step ignores triggers during dwell.
// RL9: Auto runs whole list; auto after reset.
// RL10: Auto moves on the moment dwell ends.
// RL11: Flagged step emits one strobe pulse.
// RL12: Unflagged step emits no strobe.
// RL13: Strobe flags kept in programmed order.
// RL14: Point counts read back, never values.
// RL15: Dwell sets time at point, 1 ms steps.
// RL16: List runs count times, 1..2E8, reset 1.
// RL17: Strobe is fixed width from step start.
// RL18: After final point, idle awaiting trigger.
module lts_top #(
  parameter DEPTH     = 16,
  parameter IW        = 4,
  parameter MS_CYCLES = `LTS_MS_NS / `LTS_CLK_NS
) (
  input  wire        clock,       // System clock, 100 MHz.
  input  wire        reset_n,     // Asynchronous reset, active low.
  input  wire        hsel,        // AHB slave select.
  input  wire [31:0] haddr,       // AHB address.
  input  wire [1:0]  htrans,      // AHB transfer type.
  input  wire        hwrite,      // AHB write.
  input  wire [2:0]  hsize,       // AHB size.
  input  wire [31:0] hwdata,      // AHB write data.
  input  wire        hready,      // AHB bus ready.
  output reg  [31:0] hrdata,      // AHB read data.
  output reg         hreadyout,   // AHB slave ready.
  output reg         hresp,       // AHB response, always OKAY.
  input  wire        trig_in,     // External list trigger pulse.
  output reg  [1:0]  shape_out,   // Shape kind of current point.
  output reg  [3:0]  table_out,   // User table of current point.
  output reg  [8:0]  level_out,   // Rms level of current point.
  output reg  [8:0]  clip_out,    // Clip level for clipped sine.
  output reg  [IW-1:0] point_out, // Index of current point.
  output reg         list_busy,   // List transient running.
  output reg         exec_error,  // Start check failed.
  output reg         func_strobe  // Trigger-out strobe.
);
  localparam STROBE_W = `LTS_STROBE_NS / `LTS_CLK_NS;
  localparam S_IDLE  = 4'h1;
  localparam S_CHECK = 4'h2;
  localparam S_DWELL = 4'h4;
  localparam S_WAIT  = 4'h8;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [5:0]  shp_m [0:DEPTH-1];
  reg [6:0]  rep_m [0:DEPTH-1];
  reg [26:0] dwl_m [0:DEPTH-1];
  reg        ttl_m [0:DEPTH-1];
  reg [8:0]  lvl_m [0:DEPTH-1];
  reg [19:0] slw_m [0:DEPTH-1];
  reg [IW:0] n_shp, n_rep, n_dwl, n_ttl, n_lvl, n_slw;
  reg        step_mode;
  reg [27:0] count;
  reg [8:0]  tmax;
  reg [27:0] pass;
  reg [3:0]  state;
  reg [IW-1:0] idx;
  reg [6:0]  rep_left;
  reg [7:0]  strobe_cnt;
  reg        wr_pend;
  reg [7:0]  wr_addr;
  wire       tmr_done;
  wire       chk_ok;

  // An entry past the end of its list reads as zero.
  function has;
    input [IW:0]   n;
    input [IW-1:0] i;
    begin
      has = ({1'b0, i} < n);
    end
  endfunction

  // Clamp a written repeat value into its legal range.
  function [6:0] rep_clamp;
    input [31:0] d;
    begin
      rep_clamp = (d > 32'h63) ? `LTS_REP_MAX : d[6:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite address phase and read data
  // ----------------------------------------------------------------
  wire sel = hsel && htrans[1] && hready;
  wire [IW:0] len = n_dwl;
  reg  [31:0] rd;

  // Reads answer in the data phase straight after the address phase.
  always @* begin
    rd = 32'h0;
    case (haddr[7:0])
      `LTS_A_CTRL:   rd = {31'h0, step_mode};
      `LTS_A_COUNT:  rd = {4'h0, count};
      `LTS_A_CLIP:   rd = {23'h0, clip_out};
      `LTS_A_TMAX:   rd = {23'h0, tmax};
      `LTS_A_NSHAPE: rd = {{(31-IW){1'b0}}, n_shp}; // RL14
      `LTS_A_NREP:   rd = {{(31-IW){1'b0}}, n_rep}; // RL14
      `LTS_A_NDWELL: rd = {{(31-IW){1'b0}}, n_dwl}; // RL14
      `LTS_A_NTTL:   rd = {{(31-IW){1'b0}}, n_ttl}; // RL14
      `LTS_A_NLEVEL: rd = {{(31-IW){1'b0}}, n_lvl}; // RL14
      `LTS_A_NSLEW:  rd = {{(31-IW){1'b0}}, n_slw}; // RL14
      `LTS_A_STATUS: rd = {{(30-IW){1'b0}}, idx, exec_error,
                           list_busy};
      `LTS_A_PASS:   rd = {4'h0, pass};
      default:       rd = 32'h0;
    endcase
  end

  // The slave never stretches a transfer.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= sel && hwrite;
      wr_addr   <= haddr[7:0];
      if (sel && !hwrite)
        hrdata <= rd;
    end
  end

  // ----------------------------------------------------------------
  // Register writes and list appends
  // ----------------------------------------------------------------
  wire w_ctrl  = wr_pend && (wr_addr == `LTS_A_CTRL);
  wire w_clear = wr_pend && (wr_addr == `LTS_A_CLEAR);
  wire w_list  = wr_pend && (wr_addr == `LTS_A_SHAPE  ||
                 wr_addr == `LTS_A_REPEAT || wr_addr == `LTS_A_DWELL ||
                 wr_addr == `LTS_A_TTL    || wr_addr == `LTS_A_LEVEL ||
                 wr_addr == `LTS_A_SLEW);
  // Touching list data while running aborts the transient.
  wire abort = (w_ctrl && hwdata[`LTS_CTRL_ABORT]) || w_list || w_clear;

  // Each list write appends one point; a full list drops the write.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      step_mode <= 1'b0; // RL9
      count     <= `LTS_COUNT_RST; // RL16
      clip_out  <= `LTS_CLIP_RST;
      tmax      <= `LTS_TMAX_RST;
      n_shp     <= {(IW+1){1'b0}};
      n_rep     <= {(IW+1){1'b0}};
      n_dwl     <= {(IW+1){1'b0}};
      n_ttl     <= {(IW+1){1'b0}};
      n_lvl     <= {(IW+1){1'b0}};
      n_slw     <= {(IW+1){1'b0}};
    end else if (wr_pend) begin
      case (wr_addr)
        `LTS_A_CTRL: step_mode <= hwdata[`LTS_CTRL_STEP];
        `LTS_A_COUNT:
          if (hwdata[27:0] == 28'h0 || hwdata[31:28] != 4'h0)
            count <= (hwdata[27:0] == 28'h0 && hwdata[31:28] == 4'h0)
                     ? `LTS_COUNT_RST : `LTS_COUNT_MAX; // RL16
          else if (hwdata[27:0] > `LTS_COUNT_MAX)
            count <= `LTS_COUNT_MAX; // RL16
          else
            count <= hwdata[27:0];
        `LTS_A_CLIP: clip_out <= hwdata[8:0]; // RL3
        `LTS_A_TMAX: tmax <= hwdata[8:0];
        `LTS_A_CLEAR: begin
          n_shp <= {(IW+1){1'b0}};
          n_rep <= {(IW+1){1'b0}};
          n_dwl <= {(IW+1){1'b0}};
          n_ttl <= {(IW+1){1'b0}};
          n_lvl <= {(IW+1){1'b0}};
          n_slw <= {(IW+1){1'b0}};
        end
        `LTS_A_SHAPE: if (n_shp < DEPTH) begin
          shp_m[n_shp[IW-1:0]] <= hwdata[5:0]; // RL1 RL2
          n_shp <= n_shp + 1'b1;
        end
        `LTS_A_REPEAT: if (n_rep < DEPTH) begin
          rep_m[n_rep[IW-1:0]] <= rep_clamp(hwdata); // RL6
          n_rep <= n_rep + 1'b1;
        end
        `LTS_A_DWELL: if (n_dwl < DEPTH) begin
          dwl_m[n_dwl[IW-1:0]] <= hwdata[26:0]; // RL15
          n_dwl <= n_dwl + 1'b1;
        end
        `LTS_A_TTL: if (n_ttl < DEPTH) begin
          ttl_m[n_ttl[IW-1:0]] <= hwdata[0]; // RL13
          n_ttl <= n_ttl + 1'b1;
        end
        `LTS_A_LEVEL: if (n_lvl < DEPTH) begin
          lvl_m[n_lvl[IW-1:0]] <= hwdata[8:0];
          n_lvl <= n_lvl + 1'b1;
        end
        `LTS_A_SLEW: if (n_slw < DEPTH) begin
          slw_m[n_slw[IW-1:0]] <= hwdata[19:0];
          n_slw <= n_slw + 1'b1;
        end
        default: step_mode <= step_mode;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Start-time point check
  // ----------------------------------------------------------------
  wire [1:0]  ck_shape = has(n_shp, idx) ? shp_m[idx][1:0]
                                         : `LTS_SH_SINE;
  wire [8:0]  ck_level = has(n_lvl, idx) ? lvl_m[idx] : 9'h0;
  wire [IW-1:0] pidx   = idx - 1'b1;
  wire [8:0]  ck_prev  = (idx != {IW{1'b0}} && has(n_lvl, pidx))
                         ? lvl_m[pidx] : 9'h0;
  wire [19:0] ck_slew  = has(n_slw, idx) ? slw_m[idx] : 20'h0;
  wire [26:0] ck_dwell = dwl_m[idx];

  lts_point_check u_check (
    .shape (ck_shape),
    .level (ck_level),
    .prev  (ck_prev),
    .slew  (ck_slew),
    .dwell (ck_dwell),
    .clip  (clip_out),
    .tmax  (tmax),
    .ok    (chk_ok)
  );

  // ----------------------------------------------------------------
  // Sequencer decisions
  // ----------------------------------------------------------------
  reg          go;
  reg          go_same;
  reg [IW-1:0] go_idx;
  reg          go_wrap;
  reg [3:0]    next_state;
  wire last  = ({1'b0, idx} == len - 1'b1);
  wire final_pass = (pass + 28'h1 >= count);

  // The point that becomes active next, if any, is picked here.
  always @* begin
    go         = 1'b0;
    go_same    = 1'b0;
    go_idx     = idx;
    go_wrap    = 1'b0;
    next_state = state;
    case (state)
      S_IDLE:
        if (trig_in && !abort)
          next_state = S_CHECK;
      S_CHECK:
        if (abort) begin
          next_state = S_IDLE;
        end else if (len == {(IW+1){1'b0}} || !chk_ok) begin
          next_state = S_IDLE; // RL5
        end else if (last) begin
          go         = 1'b1;
          go_idx     = {IW{1'b0}}; // RL1
          next_state = S_DWELL;
        end
      S_DWELL:
        if (abort) begin
          next_state = S_IDLE;
        end else if (tmr_done) begin
          if (rep_left != 7'h0) begin
            go      = 1'b1; // RL6
            go_same = 1'b1;
          end else if (last && final_pass) begin
            next_state = S_IDLE; // RL18
          end else if (!step_mode) begin
            go      = 1'b1; // RL10
            go_wrap = last; // RL16
            go_idx  = last ? {IW{1'b0}} : idx + 1'b1; // RL9
          end else begin
            next_state = S_WAIT; // RL8
          end
        end
      S_WAIT:
        if (abort) begin
          next_state = S_IDLE;
        end else if (trig_in) begin
          go         = 1'b1; // RL7
          go_wrap    = last;
          go_idx     = last ? {IW{1'b0}} : idx + 1'b1;
          next_state = S_DWELL;
        end
      default: next_state = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer state and point outputs
  // ----------------------------------------------------------------
  // Outputs change on the same edge as the strobe starts.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state       <= S_IDLE;
      idx         <= {IW{1'b0}};
      pass        <= 28'h0;
      rep_left    <= 7'h0;
      list_busy   <= 1'b0;
      exec_error  <= 1'b0;
      shape_out   <= `LTS_SH_SINE;
      table_out   <= 4'h0;
      level_out   <= 9'h0;
      point_out   <= {IW{1'b0}};
      func_strobe <= 1'b0;
      strobe_cnt  <= 8'h0;
    end else begin
      state     <= next_state;
      list_busy <= (next_state != S_IDLE);
      if (state == S_IDLE && next_state == S_CHECK) begin
        idx        <= {IW{1'b0}};
        pass       <= 28'h0;
        exec_error <= 1'b0;
      end else if (state == S_CHECK && !go) begin
        idx <= idx + 1'b1;
        if (next_state == S_IDLE && !abort)
          exec_error <= 1'b1; // RL5
      end
      if (go) begin
        idx       <= go_idx;
        point_out <= go_idx;
        rep_left  <= go_same ? rep_left - 7'h1 :
                     (has(n_rep, go_idx) ? rep_m[go_idx] : 7'h0); // RL6
        if (go_wrap)
          pass <= pass + 28'h1; // RL16
        shape_out <= has(n_shp, go_idx) ? shp_m[go_idx][1:0]
                                        : `LTS_SH_SINE; // RL1 RL2
        table_out <= has(n_shp, go_idx) ? shp_m[go_idx][5:2] : 4'h0;
        level_out <= has(n_lvl, go_idx) ? lvl_m[go_idx] : 9'h0;
      end
      // Pulse width is fixed; a new flagged step restarts it.
      if (go && has(n_ttl, go_idx) && ttl_m[go_idx]) begin
        func_strobe <= 1'b1; // RL11 RL13 RL17
        strobe_cnt  <= STROBE_W[7:0] - 8'h1;
      end else if (strobe_cnt != 8'h0) begin
        strobe_cnt <= strobe_cnt - 8'h1; // RL17
      end else begin
        func_strobe <= 1'b0; // RL12
      end
    end
  end

  // ----------------------------------------------------------------
  // Dwell timer
  // ----------------------------------------------------------------
  lts_dwell_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clock   (clock),
    .reset_n (reset_n),
    .load    (go),
    .stop    (next_state == S_IDLE),
    .ms      (dwl_m[go_idx]), // RL15
    .running (),
    .done    (tmr_done)
  );
endmodule

// ### rtl/lts_regs.vh
`ifndef LTS_REGS_VH
`define LTS_REGS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LTS_A_CTRL    8'h00
`define LTS_A_COUNT   8'h04
`define LTS_A_CLIP    8'h08
`define LTS_A_TMAX    8'h0c
`define LTS_A_CLEAR   8'h10
`define LTS_A_SHAPE   8'h14
`define LTS_A_REPEAT  8'h18
`define LTS_A_DWELL   8'h1c
`define LTS_A_TTL     8'h20
`define LTS_A_LEVEL   8'h24
`define LTS_A_SLEW    8'h28
`define LTS_A_NSHAPE  8'h30
`define LTS_A_NREP    8'h34
`define LTS_A_NDWELL  8'h38
`define LTS_A_NTTL    8'h3c
`define LTS_A_NLEVEL  8'h40
`define LTS_A_NSLEW   8'h44
`define LTS_A_STATUS  8'h48
`define LTS_A_PASS    8'h4c
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define LTS_CTRL_STEP  0
`define LTS_CTRL_ABORT 1
`define LTS_COUNT_RST  28'h0000001
`define LTS_COUNT_MAX  28'hbebc200
`define LTS_CLIP_RST   9'h1a9
`define LTS_TMAX_RST   9'h12c
`define LTS_REP_MAX    7'h63
// ----------------------------------------------------------------
// Shape codes and voltage limits
// ----------------------------------------------------------------
`define LTS_SH_SINE    2'h0
`define LTS_SH_A       2'h1
`define LTS_SH_CLIP    2'h2
`define LTS_SH_TABLE   2'h3
`define LTS_PEAK_MAX   9'h1a9
`define LTS_SINE_MAX   9'h12c
`define LTS_SQRT2_K    20'h00586
`define LTS_MILLI      20'h003e8
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LTS_CLK_NS     10
`define LTS_MS_NS      1000000
`define LTS_STROBE_NS  1000
`endif

// ### rtl/lts_dwell_timer.v
`timescale 1ns/100ps
`include "lts_regs.vh"
// Counts a dwell of whole milliseconds; done pulses in the last cycle.
module lts_dwell_timer #(
  parameter MS_CYCLES = `LTS_MS_NS / `LTS_CLK_NS
) (
  input  wire        clock,   // System clock.
  input  wire        reset_n, // Asynchronous reset, active low.
  input  wire        load,    // Start a new dwell.
  input  wire        stop,    // Abandon the running dwell.
  input  wire [26:0] ms,      // Dwell length in milliseconds.
  output wire        running, // Dwell in progress.
  output wire        done     // Last cycle of the dwell.
);
  reg [31:0] pre;
  reg [26:0] left;

  assign running = (left != 27'h0);
  assign done    = running && (left == 27'h1) &&
                   (pre == MS_CYCLES - 1);

  // ----------------------------------------------------------------
  // Prescaler and millisecond count
  // ----------------------------------------------------------------
  // A zero dwell is raised to one millisecond so a step never stalls.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pre  <= 32'h0;
      left <= 27'h0;
    end else if (load) begin
      pre  <= 32'h0;
      left <= (ms == 27'h0) ? 27'h1 : ms;
    end else if (stop) begin
      left <= 27'h0;
    end else if (running) begin
      if (pre == MS_CYCLES - 1) begin
        pre  <= 32'h0;
        left <= left - 27'h1;
      end else begin
        pre <= pre + 32'h1;
      end
    end
  end
endmodule

// ### rtl/lts_point_check.v
`timescale 1ns/100ps
`include "lts_regs.vh"
// Judges one list point against the peak and custom-table limits.
module lts_point_check (
  input  wire [1:0]  shape, // Shape kind of the point.
  input  wire [8:0]  level, // Rms level of the point in volts.
  input  wire [8:0]  prev,  // Rms level of the previous point.
  input  wire [19:0] slew,  // Slew rate in volts per second.
  input  wire [26:0] dwell, // Dwell in milliseconds.
  input  wire [8:0]  clip,  // Clip level in volts peak.
  input  wire [8:0]  tmax,  // Largest rms the user table allows.
  output reg         ok     // Point may run.
);
  reg [47:0] ramp;
  reg [29:0] room;
  reg [29:0] pk;

  // Shape_a peak equals rms; clipped peak is the lower of sine and clip.
  always @* begin
    ramp = {28'h0, slew} * {21'h0, dwell};
    room = (tmax > prev) ? (tmax - prev) * `LTS_MILLI : 30'h0;
    pk   = level * `LTS_SQRT2_K;
    ok   = 1'b1;
    case (shape)
      `LTS_SH_SINE: ok = (level <= `LTS_SINE_MAX); // RL4
      `LTS_SH_A:    ok = (level <= `LTS_PEAK_MAX); // RL4
      `LTS_SH_CLIP: ok = (clip <= `LTS_PEAK_MAX) && // RL3
                         (level <= `LTS_SINE_MAX || pk[29:0] >=
                          {21'h0, clip} * `LTS_MILLI); // RL4
      `LTS_SH_TABLE: ok = (level <= tmax) &&
                          (ramp <= {18'h0, room}); // RL5
      default: ok = 1'b0;
    endcase
  end
endmodule

// ### tb/lts_top_assertions.sv
`timescale 1ns/100ps
`include "lts_regs.vh"
module lts_top_assertions #(
  parameter IW        = 4,
  parameter MS_CYCLES = 100000
) (
  input wire          clock,      // System clock.
  input wire          reset_n,    // Asynchronous reset, active low.
  input wire [1:0]    shape_out,  // Shape of the current point.
  input wire [8:0]    level_out,  // Level of the current point.
  input wire [8:0]    clip_out,   // Clip level.
  input wire [IW-1:0] point_out,  // Current point index.
  input wire          list_busy,  // Run in progress.
  input wire          exec_error, // Start check failed.
  input wire          func_strobe // Trigger-out strobe.
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [7:0]  strobe_cnt;
  logic [31:0] hold_cnt;
  // Strobe length, and cycles since the point index last moved.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strobe_cnt <= 8'h00;
      hold_cnt   <= 32'h0;
    end else begin
      strobe_cnt <= func_strobe ? strobe_cnt + 8'h01 : 8'h00;
      hold_cnt   <= $changed(point_out) ? 32'h0 : hold_cnt + 32'h1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_STROBE_LEN: assert property (
    $fell(func_strobe) |-> strobe_cnt == 8'h64)
    else $error("strobe pulse was not 100 cycles");
  AST_STROBE_MAX: assert property (
    func_strobe |-> strobe_cnt < 8'h64)
    else $error("strobe pulse ran too long");
  AST_STROBE_BUSY: assert property (
    $rose(func_strobe) |-> list_busy && !exec_error)
    else $error("strobe outside a running list");
  AST_ERR_IDLE: assert property (
    $rose(exec_error) |-> ##[0:2] !list_busy)
    else $error("list kept running after a failed check");
  AST_IDLE_HOLD: assert property (
    !list_busy && !$past(list_busy) |->
      $stable(point_out) && $stable(level_out))
    else $error("point moved while idle");
  AST_SINE_CAP: assert property (
    list_busy && shape_out == `LTS_SH_SINE |->
      level_out <= `LTS_SINE_MAX)
    else $error("sine level above its cap");
  AST_PEAK_CAP: assert property (
    list_busy && shape_out == `LTS_SH_A |-> level_out <= `LTS_PEAK_MAX)
    else $error("shape_a level above the peak cap");
  AST_CLIP_CAP: assert property (
    list_busy && shape_out == `LTS_SH_CLIP |-> clip_out <= `LTS_PEAK_MAX)
    else $error("clip level above the peak cap");
  AST_DWELL_MIN: assert property (
    $changed(point_out) |-> hold_cnt >= MS_CYCLES - 1)
    else $error("point held for less than one millisecond");
  // Main scenarios are reached.
  COV_STROBE: cover property ($rose(func_strobe));
  COV_ERROR: cover property ($rose(exec_error));
  COV_DONE: cover property ($fell(list_busy));
endmodule
bind lts_top lts_top_assertions #(.IW(IW), .MS_CYCLES(MS_CYCLES)) u_chk (
  .clock, .reset_n, .shape_out, .level_out, .clip_out, .point_out,
  .list_busy, .exec_error, .func_strobe);

// ### tb/lts_host.sv
`timescale 1ns/100ps
module lts_host (
  input  wire         clock,     // System clock.
  input  wire  [31:0] hrdata,    // Read data from the block.
  input  wire         hreadyout, // Block ready, also the bus ready.
  output logic        hsel,      // Block select.
  output logic [31:0] haddr,     // Byte address.
  output logic [1:0]  htrans,    // Transfer type.
  output logic        hwrite,    // Write strobe.
  output logic [2:0]  hsize,     // Always a whole word.
  output logic [31:0] hwdata,    // Write data.
  output logic        trig_in    // Trigger source pulse.
);
  // Quiet bus and trigger from time zero.
  initial begin
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    trig_in = 1'b0;
  end
  // Address phase held until ready; the slave's speed is never assumed.
  task automatic addr(input logic [7:0] a, input logic w);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr(a, 1'b1);
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr(a, 1'b0);
    do @(posedge clock); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  // One-cycle trigger pulse.
  task automatic fire;
    @(posedge clock);
    trig_in <= 1'b1;
    @(posedge clock);
    trig_in <= 1'b0;
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
`include "lts_regs.vh"
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp); \
    end \
  end
module testbench;
  localparam int MS = 10;
  logic          clock;
  logic          reset_n;
  wire           hsel, hwrite, hreadyout, hresp, trig_in;
  wire  [31:0]   haddr, hwdata, hrdata;
  wire  [1:0]    htrans, shape_out;
  wire  [2:0]    hsize;
  wire  [3:0]    table_out, point_out;
  wire  [8:0]    level_out, clip_out;
  wire           list_busy, exec_error, func_strobe;
  int            fail_count = 0;
  int            n_checks = 0;
  // Four points: sine, shape_a, clipped sine, user table 5.
  logic [31:0]   p_shape [4] = '{32'h0, 32'h1, 32'h2, 32'h17};
  logic [31:0]   p_level [4] = '{32'h64, 32'hc8, 32'hfa, 32'h64};
  logic [31:0]   p_rep   [4] = '{32'h0, 32'h1, 32'h0, 32'h0};
  logic [31:0]   p_flag  [4] = '{32'h1, 32'h0, 32'h1, 32'h1};

  lts_top #(.MS_CYCLES(MS)) DUT (
    .clock, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .trig_in,
    .shape_out, .table_out, .level_out, .clip_out, .point_out,
    .list_busy, .exec_error, .func_strobe);
  lts_host host (
    .clock, .hrdata, .hreadyout, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .trig_in);

  // 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    host.rd(a, v);
    `CHK(v, e)
    `CHK(hresp, 1'b0)
  endtask
  task automatic prog;
    host.wr(`LTS_A_CLEAR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      host.wr(`LTS_A_SHAPE, p_shape[i]);
      host.wr(`LTS_A_REPEAT, p_rep[i]);
      host.wr(`LTS_A_DWELL, 32'hc);
      host.wr(`LTS_A_TTL, p_flag[i]);
      host.wr(`LTS_A_LEVEL, p_level[i]);
    end
  endtask
  // Reset values, count clamping and point-count readback.
  task automatic t_regs;
    rdchk(`LTS_A_CTRL, 32'h0);
    rdchk(`LTS_A_COUNT, 32'h1);
    rdchk(`LTS_A_CLIP, 32'h1a9);
    rdchk(`LTS_A_TMAX, 32'h12c);
    rdchk(8'h2c, 32'h0);
    host.wr(`LTS_A_COUNT, 32'h0);
    rdchk(`LTS_A_COUNT, 32'h1);
    host.wr(`LTS_A_COUNT, 32'hfffffff);
    rdchk(`LTS_A_COUNT, 32'hbebc200);
    prog();
    for (int a = 'h30; a <= 'h44; a += 4)
      rdchk(8'(a), (a == 'h44) ? 32'h0 : 32'h4);
    $display("test regs done");
  endtask
  // Automatic run of two passes, strobes logged as they rise.
  task automatic t_auto;
    logic [8:0] lv[$];
    logic [1:0] sh[$];
    logic [3:0] tid;
    logic       was;
    int         n1, n2;
    n1 = 0;
    n2 = 0;
    was = 1'b0;
    host.wr(`LTS_A_COUNT, 32'h2);
    host.fire();
    repeat (1400) begin
      @(negedge clock);
      if (func_strobe && !was) begin
        lv.push_back(level_out);
        sh.push_back(shape_out);
        tid = table_out;
      end
      was = func_strobe;
      n1 += (list_busy && point_out == 4'h1);
      n2 += (list_busy && point_out == 4'h2);
    end
    `CHK(lv.size(), 6)
    `CHK(lv[1], 9'hfa)
    `CHK(lv[5], 9'h64)
    `CHK(sh[1], `LTS_SH_CLIP)
    `CHK(sh[2], `LTS_SH_TABLE)
    `CHK(tid, 4'h5)
    `CHK(n1, 4 * 12 * MS)
    `CHK(n2, 2 * 12 * MS)
    `CHK(list_busy, 1'b0)
    rdchk(`LTS_A_PASS, 32'h1);
    $display("test auto done");
  endtask
  // Single-step: triggers inside a dwell are dropped.
  task automatic t_step;
    host.wr(`LTS_A_CTRL, 32'h1);
    host.wr(`LTS_A_COUNT, 32'h1);
    host.fire();
    repeat (30) @(negedge clock);
    `CHK(func_strobe, 1'b1)
    host.fire();
    repeat (150) @(negedge clock);
    `CHK(point_out, 4'h0)
    `CHK(list_busy, 1'b1)
    host.fire();
    @(negedge clock);
    `CHK(point_out, 4'h1)
    `CHK(func_strobe, 1'b0)
    repeat (300) @(negedge clock);
    host.fire();
    repeat (150) @(negedge clock);
    host.fire();
    @(negedge clock);
    `CHK(point_out, 4'h3)
    repeat (150) @(negedge clock);
    `CHK(list_busy, 1'b0)
    $display("test step done");
  endtask
  // Start checks: over-limit points refuse, the 300 V sine runs.
  task automatic t_err;
    logic [31:0] s [5] = '{32'h0, 32'h1, 32'h3, 32'h3, 32'h0};
    logic [31:0] l [5] = '{32'h12d, 32'h1aa, 32'h12d, 32'hc8, 32'h12c};
    logic [31:0] r [5] = '{32'h0, 32'h0, 32'h0, 32'h61a80, 32'h0};
    host.wr(`LTS_A_CTRL, 32'h0);
    for (int i = 0; i < 5; i++) begin
      host.wr(`LTS_A_CLEAR, 32'h0);
      host.wr(`LTS_A_SHAPE, s[i]);
      host.wr(`LTS_A_LEVEL, l[i]);
      host.wr(`LTS_A_SLEW, r[i]);
      host.wr(`LTS_A_DWELL, 32'h1);
      host.fire();
      repeat (8) @(negedge clock);
      `CHK(exec_error, (i < 4))
      `CHK(list_busy, (i == 4))
    end
    $display("test error done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence after 12 cycles of reset.
  initial begin
    reset_n = 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    t_regs();
    t_auto();
    t_step();
    t_err();
    complete_run();
  end
  // Cuts a hung run short; the tests need about 2500 cycles.
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
endmodule
